//--- irqg2_ctrl.sv
// Functional notes
// RULE1 - Read-only upper pin interrupt status, sixteen bits
// RULE2 - Infrared status bit 4 shows unit interrupt
// RULE3 - Bits 3..0 show DMA page interrupts
// RULE4 - Page 2 status stops infrared DMA requests
// RULE5 - Page 1 status stops DMA if enabled
// RULE6 - Group 2 mask: six enable bits, 1 enables
// RULE7 - Reserved bits written zero, read zero
// RULE8 - Read/write upper pin mask, one per pin
// RULE9 - All mask bits reset to zero
// RULE10 - Output needs status and mask; status stays readable
`timescale 1ns/1ps
`default_nettype none
`include "irqg2_params.svh"

module irqg2_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire irqg2_pkg::irqg2_apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pin_irq_bits,
  input wire irqg2_pkg::irqg2_fir_src_t fir_src,
  input wire irqg2_pkg::irqg2_sys2_src_t sys2_src,
  input wire logic page1_irq_enable,
  input wire logic ir_dma_req_in,
  output logic ir_dma_req_out,
  output logic gpio_upper_irq,
  output logic infrared_summary_irq,
  output logic group2_irq,
  output logic irq
);
  import irqg2_pkg::*;

  logic [15:0] gpio_stat;
  logic [4:0] fir_stat;
  logic [15:0] gpio_mask;
  logic [5:0] sys2_mask;
  logic [4:0] fir_en;
  logic [15:0] gpio_clr;
  logic [4:0] fir_clr;
  logic [4:0] fir_set;
  logic [5:0] sys2_vec;
  logic setup_ph;
  logic access_wr;
  logic hit;
  logic [31:0] next_prdata;
  logic next_err;
  logic dma_stop;

  assign setup_ph = apb.psel && !apb.penable;
  assign access_wr = apb.psel && apb.penable && apb.pwrite;
  assign pready = 1'b1;

  // Address decode, shared by read mux and error flag
  always_comb begin
    hit = 1'b1;
    next_prdata = `IRQG2_RST_32;
    unique case (apb.paddr)
      `IRQG2_ADDR_GPIO_STAT: next_prdata = {16'h0000, gpio_stat}; // [RULE1]
      `IRQG2_ADDR_FIR_STAT: next_prdata = {27'h0000000, fir_stat}; // [RULE2] [RULE3] [RULE7]
      `IRQG2_ADDR_SYS2_MASK: next_prdata = {26'h0000000, sys2_mask}; // [RULE6] [RULE7]
      `IRQG2_ADDR_GPIO_MASK: next_prdata = {16'h0000, gpio_mask}; // [RULE8]
      `IRQG2_ADDR_FIR_EN: next_prdata = {27'h0000000, fir_en};
      `IRQG2_ADDR_GPIO_CLR: next_prdata = `IRQG2_RST_32;
      `IRQG2_ADDR_FIR_CLR: next_prdata = `IRQG2_RST_32;
      default: hit = 1'b0;
    endcase
    next_err = !hit;
  end

  // Read data captured in the setup cycle, held through the access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= `IRQG2_RST_32;
    end else if (setup_ph && !apb.pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= next_err;
    end
  end

  // Mask registers; reserved bits are not stored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sys2_mask <= `IRQG2_RST_6; // [RULE9]
    end else if (access_wr && apb.paddr == `IRQG2_ADDR_SYS2_MASK) begin
      sys2_mask <= apb.pwdata[`IRQG2_SYS2_W-1:0]; // [RULE6] [RULE7]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gpio_mask <= `IRQG2_RST_16; // [RULE9]
    end else if (access_wr && apb.paddr == `IRQG2_ADDR_GPIO_MASK) begin
      gpio_mask <= apb.pwdata[`IRQG2_REG_W-1:0]; // [RULE8]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fir_en <= `IRQG2_RST_5; // [RULE9]
    end else if (access_wr && apb.paddr == `IRQG2_ADDR_FIR_EN) begin
      fir_en <= apb.pwdata[`IRQG2_FIR_W-1:0];
    end
  end

  // Write-one-to-clear strobes, one cycle wide
  assign gpio_clr = (access_wr && apb.paddr == `IRQG2_ADDR_GPIO_CLR) ? apb.pwdata[`IRQG2_REG_W-1:0] : `IRQG2_RST_16;
  assign fir_clr = (access_wr && apb.paddr == `IRQG2_ADDR_FIR_CLR) ? apb.pwdata[`IRQG2_FIR_W-1:0] : `IRQG2_RST_5;
  assign fir_set = {fir_src.infrared_unit_irq, fir_src.infrared_dma_page_irq};

  irqg2_sticky #(.W(`IRQG2_REG_W)) u_gpio_stat (
    .clk(clk),
    .sys_rst(sys_rst),
    .set(pin_irq_bits), // [RULE1]
    .clr(gpio_clr),
    .stat(gpio_stat)
  );

  irqg2_sticky #(.W(`IRQG2_FIR_W)) u_fir_stat (
    .clk(clk),
    .sys_rst(sys_rst),
    .set(fir_set), // [RULE2] [RULE3]
    .clr(fir_clr),
    .stat(fir_stat)
  );

  // DMA gating follows the status bits directly
  assign dma_stop = fir_stat[`IRQG2_FIR_P2_RX] || fir_stat[`IRQG2_FIR_P2_TX] // [RULE4]
    || (page1_irq_enable && (fir_stat[`IRQG2_FIR_P1_RX] || fir_stat[`IRQG2_FIR_P1_TX])); // [RULE5]
  assign ir_dma_req_out = ir_dma_req_in && !dma_stop;

  assign sys2_vec = {sys2_src.debug_serial_irq, infrared_summary_irq, sys2_src.tick_counter_irq,
    sys2_src.signal_processor_irq, sys2_src.indicator_lamp_irq, sys2_src.long_timer2_irq};

  // Masking gates only the outputs; status bits are untouched
  assign gpio_upper_irq = |(gpio_stat & gpio_mask); // [RULE10]
  assign infrared_summary_irq = |(fir_stat & fir_en); // [RULE10]
  assign group2_irq = |(sys2_vec & sys2_mask); // [RULE6] [RULE10]
  assign irq = gpio_upper_irq || group2_irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic wr_sys2;
  logic wr_gpio_mask;
  logic wr_gpio_clr;
  logic wr_fir_clr;
  assign wr_sys2 = access_wr && apb.paddr == `IRQG2_ADDR_SYS2_MASK;
  assign wr_gpio_mask = access_wr && apb.paddr == `IRQG2_ADDR_GPIO_MASK;
  assign wr_gpio_clr = access_wr && apb.paddr == `IRQG2_ADDR_GPIO_CLR;
  assign wr_fir_clr = access_wr && apb.paddr == `IRQG2_ADDR_FIR_CLR;

  // Extra write decodes used only by the checks below
  logic wr_fir_en;
  logic wr_gpio_stat;
  assign wr_fir_en = access_wr && apb.paddr == `IRQG2_ADDR_FIR_EN;
  assign wr_gpio_stat = access_wr && apb.paddr == `IRQG2_ADDR_GPIO_STAT;

  sequence seq_gpio_mask_off;
    wr_gpio_mask && apb.pwdata[15:0] == 16'h0000 && gpio_stat != 16'h0000 && pin_irq_bits == 16'h0000
      && !wr_gpio_clr;
  endsequence

  sequence seq_read_setup(logic [31:0] a);
    setup_ph && !apb.pwrite && apb.paddr == a;
  endsequence

  chk_gpio_set_sticky: assert property ( // [RULE1]
    pin_irq_bits != 16'h0000 |=> (gpio_stat & $past(pin_irq_bits)) == $past(pin_irq_bits))
    else $error("pin event not latched in status");

  chk_gpio_stat_hold: assert property ( // [RULE1]
    pin_irq_bits == 16'h0000 && !wr_gpio_clr |=> $stable(gpio_stat))
    else $error("pin status changed without event or clear");

  chk_set_beats_clr: assert property ( // [RULE1]
    wr_gpio_clr && pin_irq_bits != 16'h0000 |=> (gpio_stat & $past(pin_irq_bits)) == $past(pin_irq_bits))
    else $error("clear lost a same-cycle pin event");

  chk_fir_unit_set: assert property ( // [RULE2]
    fir_src.infrared_unit_irq |=> fir_stat[4] && (infrared_summary_irq || !fir_en[4]))
    else $error("infrared unit event not shown in bit 4");

  chk_fir_page_set: assert property ( // [RULE3]
    fir_src.infrared_dma_page_irq != 4'h0 && !wr_fir_clr
      |=> (fir_stat[3:0] & $past(fir_src.infrared_dma_page_irq)) == $past(fir_src.infrared_dma_page_irq))
    else $error("page event not shown in status");

  chk_dma_p2_stop: assert property ( // [RULE4]
    fir_src.infrared_dma_page_irq[3:2] != 2'b00 |=> !ir_dma_req_out ##1 (!ir_dma_req_out || $past(wr_fir_clr)))
    else $error("DMA request passed with page 2 status set");

  chk_dma_p1_stop: assert property ( // [RULE5]
    (fir_stat[1] || fir_stat[0]) && page1_irq_enable |-> !ir_dma_req_out)
    else $error("DMA request passed with enabled page 1 status");

  chk_dma_p1_pass: assert property ( // [RULE5]
    !page1_irq_enable && fir_stat[3:2] == 2'b00 && ir_dma_req_in |-> ir_dma_req_out)
    else $error("DMA request blocked without cause");

  chk_sys2_mask_wr: assert property ( // [RULE6]
    wr_sys2 |=> sys2_mask == $past(apb.pwdata[5:0]))
    else $error("group 2 mask write not stored");

  chk_reserved_zero: assert property ( // [RULE7]
    seq_read_setup(`IRQG2_ADDR_FIR_STAT) or seq_read_setup(`IRQG2_ADDR_SYS2_MASK)
      |=> prdata[31:6] == 26'h0000000 && (prdata[5] == 1'b0 || $past(apb.paddr) == `IRQG2_ADDR_SYS2_MASK))
    else $error("reserved bits read non-zero");

  chk_gpio_mask_rd: assert property ( // [RULE8]
    seq_read_setup(`IRQG2_ADDR_GPIO_MASK) |=> prdata == {16'h0000, $past(gpio_mask)})
    else $error("pin mask readback differs from register");

  chk_gpio_mask_wr: assert property ( // [RULE8]
    wr_gpio_mask |=> gpio_mask == $past(apb.pwdata[15:0]))
    else $error("pin mask write not stored");

  chk_gpio_mask_hold: assert property ( // [RULE8]
    !wr_gpio_mask |=> $stable(gpio_mask))
    else $error("pin mask changed without a write");

  chk_sys2_mask_hold: assert property ( // [RULE6]
    !wr_sys2 |=> $stable(sys2_mask))
    else $error("group 2 mask changed without a write");

  chk_fir_en_wr: assert property ( // [RULE10]
    wr_fir_en |=> fir_en == $past(apb.pwdata[4:0]))
    else $error("infrared enable write not stored");

  chk_gpio_stat_ro: assert property ( // [RULE1]
    wr_gpio_stat && pin_irq_bits == 16'h0000 |=> $stable(gpio_stat))
    else $error("write changed read-only pin status");

  chk_gpio_clr_works: assert property ( // [RULE1]
    wr_gpio_clr && pin_irq_bits == 16'h0000 |=> (gpio_stat & $past(apb.pwdata[15:0])) == 16'h0000)
    else $error("pin status clear had no effect");

  chk_fir_stat_hold: assert property ( // [RULE3]
    fir_set == 5'h00 && !wr_fir_clr |=> $stable(fir_stat))
    else $error("infrared status changed without event or clear");

  chk_fir_clr_works: assert property ( // [RULE2]
    wr_fir_clr && fir_set == 5'h00 |=> (fir_stat & $past(apb.pwdata[4:0])) == 5'h00)
    else $error("infrared status clear had no effect");

  chk_rd_gpio_stat: assert property ( // [RULE1]
    seq_read_setup(`IRQG2_ADDR_GPIO_STAT) |=> prdata == {16'h0000, $past(gpio_stat)})
    else $error("pin status readback differs");

  chk_rd_fir_stat: assert property ( // [RULE2]
    seq_read_setup(`IRQG2_ADDR_FIR_STAT) |=> prdata == {27'h0000000, $past(fir_stat)})
    else $error("infrared status readback differs");

  chk_rd_sys2_mask: assert property ( // [RULE6]
    seq_read_setup(`IRQG2_ADDR_SYS2_MASK) |=> prdata == {26'h0000000, $past(sys2_mask)})
    else $error("group 2 mask readback differs");

  chk_err_unmapped: assert property ( // [RULE7]
    setup_ph && !hit |=> pslverr)
    else $error("unmapped access not flagged");

  chk_err_mapped: assert property ( // [RULE7]
    setup_ph && hit |=> !pslverr)
    else $error("mapped access flagged as error");

  chk_dma_idle_pass: assert property ( // [RULE4]
    fir_stat[3:0] == 4'h0 && ir_dma_req_in |-> ir_dma_req_out)
    else $error("DMA request blocked with no page status");

  chk_dma_no_req: assert property ( // [RULE4]
    !ir_dma_req_in |-> !ir_dma_req_out)
    else $error("DMA request issued without a source request");

  chk_gpio_gate: assert property ( // [RULE10]
    gpio_mask == 16'h0000 |-> !gpio_upper_irq)
    else $error("pin output high while fully masked");

  chk_fir_gate: assert property ( // [RULE10]
    fir_en == 5'h00 |-> !infrared_summary_irq)
    else $error("infrared output high while disabled");

  chk_summary_feed: assert property ( // [RULE6]
    infrared_summary_irq && sys2_mask[4] |-> group2_irq)
    else $error("enabled infrared summary not passed to group 2");

  chk_irq_merge: assert property ( // [RULE10]
    irq == (gpio_upper_irq || group2_irq))
    else $error("combined output differs from its sources");

  chk_pin_irq_path: assert property ( // [RULE10]
    (gpio_stat & gpio_mask) != 16'h0000 |-> gpio_upper_irq && irq)
    else $error("enabled pin status not passed onward");

  chk_mask_reset: assert property ( // [RULE9]
    $fell(sys_rst) |-> gpio_mask == 16'h0000 && sys2_mask == 6'h00 && fir_en == 5'h00 && !irq)
    else $error("mask not zero after reset");

  chk_mask_keeps_stat: assert property ( // [RULE10]
    seq_gpio_mask_off |=> !gpio_upper_irq && gpio_stat == $past(gpio_stat))
    else $error("masking altered status or left output high");

  chk_group2_gate: assert property ( // [RULE10]
    sys2_mask == 6'h00 |-> !group2_irq)
    else $error("group 2 output high while fully masked");

endmodule : irqg2_ctrl
`default_nettype wire

//--- irqg2_params.svh
`ifndef IRQG2_PARAMS_SVH
`define IRQG2_PARAMS_SVH

// Register indices as printed; byte address is four times the index
`define IRQG2_IDX_GPIO_STAT 32'h0B00_0202
`define IRQG2_IDX_FIR_STAT 32'h0B00_0204
`define IRQG2_IDX_SYS2_MASK 32'h0B00_0206
`define IRQG2_IDX_GPIO_MASK 32'h0B00_0208
`define IRQG2_IDX_GPIO_CLR 32'h0B00_0210
`define IRQG2_IDX_FIR_CLR 32'h0B00_0212
`define IRQG2_IDX_FIR_EN 32'h0B00_0214

`define IRQG2_WORD_BYTES 32'h0000_0004
`define IRQG2_ADDR_GPIO_STAT (`IRQG2_IDX_GPIO_STAT * `IRQG2_WORD_BYTES)
`define IRQG2_ADDR_FIR_STAT (`IRQG2_IDX_FIR_STAT * `IRQG2_WORD_BYTES)
`define IRQG2_ADDR_SYS2_MASK (`IRQG2_IDX_SYS2_MASK * `IRQG2_WORD_BYTES)
`define IRQG2_ADDR_GPIO_MASK (`IRQG2_IDX_GPIO_MASK * `IRQG2_WORD_BYTES)
`define IRQG2_ADDR_GPIO_CLR (`IRQG2_IDX_GPIO_CLR * `IRQG2_WORD_BYTES)
`define IRQG2_ADDR_FIR_CLR (`IRQG2_IDX_FIR_CLR * `IRQG2_WORD_BYTES)
`define IRQG2_ADDR_FIR_EN (`IRQG2_IDX_FIR_EN * `IRQG2_WORD_BYTES)

`define IRQG2_REG_W 16
`define IRQG2_FIR_W 5
`define IRQG2_SYS2_W 6
`define IRQG2_RST_16 16'h0000
`define IRQG2_RST_5 5'h00
`define IRQG2_RST_6 6'h00
`define IRQG2_RST_32 32'h0000_0000

// Infrared status field positions
`define IRQG2_FIR_UNIT 4
`define IRQG2_FIR_P2_RX 3
`define IRQG2_FIR_P2_TX 2
`define IRQG2_FIR_P1_RX 1
`define IRQG2_FIR_P1_TX 0

// Group 2 mask field positions
`define IRQG2_SYS2_DEBUG 5
`define IRQG2_SYS2_IR 4
`define IRQG2_SYS2_TICK 3
`define IRQG2_SYS2_SIGP 2
`define IRQG2_SYS2_LAMP 1
`define IRQG2_SYS2_LTMR2 0

`endif

//--- irqg2_pkg.sv
package irqg2_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } irqg2_apb_req_t;

  typedef struct packed {
    logic infrared_unit_irq;
    logic [3:0] infrared_dma_page_irq;
  } irqg2_fir_src_t;

  typedef struct packed {
    logic debug_serial_irq;
    logic tick_counter_irq;
    logic signal_processor_irq;
    logic indicator_lamp_irq;
    logic long_timer2_irq;
  } irqg2_sys2_src_t;

endpackage : irqg2_pkg

//--- irqg2_sticky.sv
`timescale 1ns/1ps
`default_nettype none
`include "irqg2_params.svh"

module irqg2_sticky #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] stat
);
  import irqg2_pkg::*;

  // Set is applied after clear so a new event in the clear cycle survives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~clr) | set;
    end
  end

endmodule : irqg2_sticky
`default_nettype wire

//--- irqg2_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- irqg2_periph.sv
`timescale 1ns/1ps
`default_nettype none

module irqg2_periph (
  input wire logic clk,
  input wire logic [15:0] pin_ev,
  input wire logic [4:0] fir_ev,
  input wire logic [4:0] sys_lvl,
  output logic [15:0] pin_irq_bits,
  output var irqg2_pkg::irqg2_fir_src_t fir_src,
  output var irqg2_pkg::irqg2_sys2_src_t sys2_src
);
  import irqg2_pkg::*;
  // Peripheral events leave on the bus clock, one cycle after the request
  always_ff @(posedge clk) begin
    pin_irq_bits <= pin_ev;
    fir_src <= fir_ev;
    sys2_src <= sys_lvl;
  end
endmodule : irqg2_periph

`default_nettype wire

//--- irq_status_mask_group2_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "irqg2_params.svh"

module irq_status_mask_group2_bench;
  import irqg2_pkg::*;
  logic clk = 1'b0;
  logic sys_rst;
  irqg2_apb_req_t apb;
  logic [31:0] prdata, r;
  logic pready, pslverr, err, page1_irq_enable, ir_dma_req_in, ir_dma_req_out;
  logic gpio_upper_irq, infrared_summary_irq, group2_irq, irq;
  logic [15:0] pin_ev, pin_irq_bits;
  logic [4:0] fir_ev, sys_lvl;
  irqg2_fir_src_t fir_src;
  irqg2_sys2_src_t sys2_src;
  int n_mismatch = 0;
  int tests_run = 0;

  always #50 clk = ~clk;

  irqg2_periph u_periph (.clk(clk), .pin_ev(pin_ev), .fir_ev(fir_ev), .sys_lvl(sys_lvl),
    .pin_irq_bits(pin_irq_bits), .fir_src(fir_src), .sys2_src(sys2_src));

  irqg2_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .apb(apb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_irq_bits(pin_irq_bits), .fir_src(fir_src), .sys2_src(sys2_src),
    .page1_irq_enable(page1_irq_enable), .ir_dma_req_in(ir_dma_req_in),
    .ir_dma_req_out(ir_dma_req_out), .gpio_upper_irq(gpio_upper_irq),
    .infrared_summary_irq(infrared_summary_irq), .group2_irq(group2_irq), .irq(irq));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      n_mismatch++;
      wrap_up();
    end else begin
      r = prdata;
      err = pslverr;
      apb <= '0;
      @(negedge clk);
    end
  endtask : xfer

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, r);
  endtask : rd

  task automatic ev(input logic [15:0] p, input logic [4:0] f);
    @(posedge clk);
    pin_ev <= p;
    fir_ev <= f;
    @(posedge clk);
    pin_ev <= '0;
    fir_ev <= '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : ev

  initial begin
    sys_rst = 1'b1;
    apb = '0;
    pin_ev = '0;
    fir_ev = '0;
    sys_lvl = '0;
    page1_irq_enable = 1'b0;
    ir_dma_req_in = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`IRQG2_ADDR_GPIO_STAT, 32'h0, "gpio_stat");
    rd(`IRQG2_ADDR_FIR_STAT, 32'h0, "fir_stat");
    rd(`IRQG2_ADDR_SYS2_MASK, 32'h0, "sys2_mask");
    rd(`IRQG2_ADDR_GPIO_MASK, 32'h0, "gpio_mask");
    xfer(1'b1, 32'h0000_1000, 32'hFFFF_FFFF);
    chk("pslverr", 32'h1, {31'h0, err});
    xfer(1'b1, `IRQG2_ADDR_GPIO_MASK, 32'h0000_A5A5);
    rd(`IRQG2_ADDR_GPIO_MASK, 32'h0000_A5A5, "gpio_mask");
    xfer(1'b1, `IRQG2_ADDR_SYS2_MASK, 32'h0000_003F);
    rd(`IRQG2_ADDR_SYS2_MASK, 32'h0000_003F, "sys2_mask");
    xfer(1'b1, `IRQG2_ADDR_GPIO_STAT, 32'h0000_FFFF);
    rd(`IRQG2_ADDR_GPIO_STAT, 32'h0, "gpio_stat_ro");
    ev(16'h0009, 5'h00);
    rd(`IRQG2_ADDR_GPIO_STAT, 32'h0000_0009, "gpio_stat");
    chk("irq", 32'h1, {31'h0, irq});
    xfer(1'b1, `IRQG2_ADDR_GPIO_MASK, 32'h0000_0008);
    chk("gpio_upper_irq", 32'h1, {31'h0, gpio_upper_irq});
    xfer(1'b1, `IRQG2_ADDR_GPIO_MASK, 32'h0000_0000);
    chk("gpio_upper_irq", 32'h0, {31'h0, gpio_upper_irq});
    rd(`IRQG2_ADDR_GPIO_STAT, 32'h0000_0009, "gpio_stat_kept");
    xfer(1'b1, `IRQG2_ADDR_GPIO_CLR, 32'h0000_FFFF);
    @(posedge clk);
    sys_lvl <= 5'b01000;
    repeat (3) @(negedge clk);
    chk("group2_irq", 32'h1, {31'h0, group2_irq});
    xfer(1'b1, `IRQG2_ADDR_SYS2_MASK, 32'h0000_0037);
    chk("group2_irq", 32'h0, {31'h0, group2_irq});
    @(posedge clk);
    sys_lvl <= 5'b00000;
    xfer(1'b1, `IRQG2_ADDR_FIR_EN, 32'h0000_001F);
    ev(16'h0000, 5'h10);
    rd(`IRQG2_ADDR_FIR_STAT, 32'h0000_0010, "fir_stat");
    chk("group2_irq", 32'h1, {31'h0, group2_irq});
    chk("infrared_summary_irq", 32'h1, {31'h0, infrared_summary_irq});
    chk("dma_out", 32'h1, {31'h0, ir_dma_req_out});
    xfer(1'b1, `IRQG2_ADDR_FIR_CLR, 32'h0000_001F);
    for (int k = 0; k < 4; k++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        page1_irq_enable <= p[0];
        ev(16'h0000, 5'(1 << k));
        rd(`IRQG2_ADDR_FIR_STAT, 32'(1 << k), "fir_page");
        chk("dma_out", {31'h0, !(k >= 2 || p == 1)}, {31'h0, ir_dma_req_out});
        xfer(1'b1, `IRQG2_ADDR_FIR_CLR, 32'h0000_001F);
      end
    end
    @(posedge clk);
    ir_dma_req_in <= 1'b0;
    @(negedge clk);
    chk("dma_idle", 32'h0, {31'h0, ir_dma_req_out});
    wrap_up();
  end
endmodule : irq_status_mask_group2_bench

`default_nettype wire
